// ===== pkg/spi_xfer_pkg.sv
package spi_xfer_pkg;
   // ----------------------------------------
   // word and buffer sizes
   // ----------------------------------------
   localparam int WORD_W = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int BUF_DEPTH = 2;
   localparam int DIV_W = 8;
   localparam int SEL_W = 8;
   // ----------------------------------------
   // control word field positions
   // ----------------------------------------
   localparam int CTL_VARCLK_BIT = 23;
   localparam int CTL_FIFO_BIT = 21;
   localparam int CTL_SLAVE_BIT = 18;
   localparam int CTL_GAP_MSB = 15;
   localparam int CTL_GAP_LSB = 12;
   localparam int CTL_POL_BIT = 11;
   localparam int CTL_LSB_BIT = 10;
   localparam int CTL_LEN_MSB = 7;
   localparam int CTL_LEN_LSB = 3;
   localparam int CTL_DRV_BIT = 2;
   localparam int CTL_SMP_BIT = 1;
   localparam logic [31:0] CTL_RESET = 32'h0000_3000;
   // ----------------------------------------
   // select config field positions
   // ----------------------------------------
   localparam int SEL_LEVEL_BIT = 2;
   localparam int SEL_TRIG_BIT = 4;
   localparam logic [7:0] SEL_RESET = 8'h00;
   // ----------------------------------------
   // word length in bits; gap counts in half serial clock periods
   // ----------------------------------------
   localparam logic [5:0] LEN_FULL = 6'h20;
   localparam logic [5:0] GAP_BASE_HALVES = 6'h01;
   localparam logic [5:0] GAP_VARCLK_HALVES = 6'h0D;
   localparam logic [5:0] GAP_PLAIN_HALVES = 6'h01;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_GAP = 2'b11
   } master_state_t;
endpackage

// ===== verilog/spi_word_fifo.sv
`timescale 1ns/1ps
module spi_word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic room_q, avail_q;
   logic [WIDTH-1:0] head_q, head_d;
   logic push, pop;

   assign push = in_valid & room_q;
   assign pop = out_ready & avail_q;
   // ready, valid and the head word all leave straight from flops
   assign in_ready = room_q;
   assign out_valid = avail_q;
   assign out_data = head_q;
   assign rd_d = pop ? rd_q + AW'(1) : rd_q;
   // a word written into the slot about to be read bypasses the array
   assign head_d = (push && wr_q == rd_d) ? in_data : mem[rd_d];

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + (AW+1)'(1);
      end else if (pop && !push) begin
         cnt_d = cnt_q - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         room_q <= 1'b1;
         avail_q <= 1'b0;
         head_q <= '0;
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         room_q <= (cnt_d != (AW+1)'(DEPTH));
         avail_q <= (cnt_d != '0);
         head_q <= head_d;
         if (push) begin
            wr_q <= wr_q + AW'(1);
         end
         rd_q <= rd_d;
      end
   end

   // storage carries no reset so it maps onto plain memory
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
endmodule

// ===== verilog/spi_core_transfer_config.sv
`timescale 1ns/1ps
module spi_core_transfer_config (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic [31:0] control_word,
   input wire logic [spi_xfer_pkg::SEL_W-1:0] select_config,
   input wire logic [spi_xfer_pkg::DIV_W-1:0] divider,
   input wire logic [spi_xfer_pkg::WORD_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [spi_xfer_pkg::WORD_W-1:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic busy,
   output logic transfer_done,
   output logic level_mode_complete_flag,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe_n,
   input wire logic select_pin_in,
   output logic select_pin_out,
   output logic select_pin_oe_n,
   input wire logic master_out_pin_in,
   output logic master_out_pin_out,
   output logic master_out_pin_oe_n,
   input wire logic master_in_pin_in,
   output logic master_in_pin_out,
   output logic master_in_pin_oe_n
);
   import spi_xfer_pkg::*;

   master_state_t st_q, st_d;
   logic [31:0] cfg_q;
   logic [SEL_W-1:0] sel_q;
   logic [DIV_W-1:0] div_q, div_cnt_q;
   logic [6:0] edge_cnt_q;
   logic [5:0] gap_cnt_q, samp_cnt_q, len, gap_halves;
   logic [WORD_W-1:0] tx_sh_q, rx_sh_q, fifo_word, tx_word;
   logic sclk_q, dout_q, busy_q, sel_out_q, done_q, flag_q, rx_push_q;
   logic sclk_oe_n_q, sel_oe_n_q, mo_oe_n_q, mi_oe_n_q;
   logic sclk_in_q, sclk_prev_q, ss_in_q, ss_prev_q, mosi_in_q, s_act_q;
   logic cfg_slave, cfg_pol, cfg_lsb, level_trig, ss_act, ss_prev_act;
   logic tick, last_edge, more_ok, take_m, m_done;
   logic s_start, s_end, s_full, s_load, s_push;
   logic edge_ev, edge_rise, drive_ev, sample_ev, sdi, take_any;
   logic tx_out_valid, rx_in_ready, buf_valid, buf_ready;
   logic [WORD_W-1:0] buf_data;

   assign cfg_slave = cfg_q[CTL_SLAVE_BIT];
   assign cfg_pol = cfg_q[CTL_POL_BIT];
   assign cfg_lsb = cfg_q[CTL_LSB_BIT];
   assign level_trig = ~sel_q[SEL_TRIG_BIT];
   // word length 0 encodes a full 32-bit word
   assign len = (cfg_q[CTL_LEN_MSB:CTL_LEN_LSB] == 5'h00) ? LEN_FULL
                : {1'b0, cfg_q[CTL_LEN_MSB:CTL_LEN_LSB]};

   function automatic logic [4:0] bit_pos(input logic [5:0] n, input logic [5:0] l,
                                          input logic lsb_first);
      logic [5:0] p;
      p = lsb_first ? n : l - 6'h01 - n;
      return p[4:0];
   endfunction
   // ----------------------------------------
   // transmit, receive and output buffering
   // ----------------------------------------
   spi_word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(fifo_word),
      .out_valid(tx_out_valid),
      .out_ready(take_any)
   );

   spi_word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(rx_sh_q),
      .in_valid(rx_push_q),
      .in_ready(rx_in_ready),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(buf_ready)
   );

   spi_word_fifo #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_out_buf (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(buf_data),
      .in_valid(buf_valid),
      .in_ready(buf_ready),
      .out_data(rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );

   assign tx_word = tx_out_valid ? fifo_word : '0;
   // ----------------------------------------
   // configuration capture
   // ----------------------------------------
   // a word in flight keeps its settings; changes wait for idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CTL_RESET;
         sel_q <= SEL_RESET;
         div_q <= '0;
      end else if (st_q == ST_IDLE && !s_act_q) begin
         cfg_q <= control_word;
         sel_q <= select_config;
         div_q <= divider;
      end
   end
   // ----------------------------------------
   // master sequencing
   // ----------------------------------------
   assign tick = (div_cnt_q == div_q);
   assign last_edge = (edge_cnt_q + 7'h01) == {len, 1'b0};
   // a new word needs room for its answer, so a full receiver stalls
   assign more_ok = enable & tx_out_valid & rx_in_ready;

   always_comb begin
      if (!cfg_q[CTL_FIFO_BIT]) begin
         gap_halves = GAP_PLAIN_HALVES;
      end else if (cfg_q[CTL_VARCLK_BIT]) begin
         gap_halves = GAP_VARCLK_HALVES + {1'b0, cfg_q[CTL_GAP_MSB:CTL_GAP_LSB], 1'b0};
      end else begin
         gap_halves = GAP_BASE_HALVES + {1'b0, cfg_q[CTL_GAP_MSB:CTL_GAP_LSB], 1'b0};
      end
   end

   always_comb begin
      st_d = st_q;
      take_m = 1'b0;
      m_done = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            if (more_ok && !cfg_slave) begin
               take_m = 1'b1;
               st_d = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (tick && last_edge) begin
               m_done = 1'b1;
               if (gap_halves != GAP_BASE_HALVES) begin
                  st_d = ST_GAP;
               end else if (more_ok) begin
                  take_m = 1'b1;
               end else begin
                  st_d = ST_IDLE;
               end
            end
         end
         ST_GAP: begin
            if (tick && gap_cnt_q == 6'h01) begin
               take_m = more_ok;
               st_d = more_ok ? ST_SHIFT : ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         div_cnt_q <= '0;
         edge_cnt_q <= '0;
         gap_cnt_q <= '0;
      end else begin
         st_q <= st_d;
         div_cnt_q <= (tick || st_q == ST_IDLE) ? '0 : div_cnt_q + 8'h01;
         if (take_m) begin
            edge_cnt_q <= '0;
         end else if (st_q == ST_SHIFT && tick) begin
            edge_cnt_q <= edge_cnt_q + 7'h01;
         end
         if (m_done) begin
            gap_cnt_q <= gap_halves - 6'h01;
         end else if (st_q == ST_GAP && tick) begin
            gap_cnt_q <= gap_cnt_q - 6'h01;
         end
      end
   end

   // serial clock toggles once per divided tick, resting at polarity
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q <= 1'b0;
      end else if (st_q == ST_SHIFT && tick) begin
         sclk_q <= ~sclk_q;
      end else if (st_q == ST_IDLE) begin
         sclk_q <= cfg_pol;
      end
   end
   // ----------------------------------------
   // slave select tracking
   // ----------------------------------------
   // pins are synchronous to clk; one stage aligns data with clock edges
   assign ss_act = (ss_in_q == sel_q[SEL_LEVEL_BIT]);
   assign ss_prev_act = (ss_prev_q == sel_q[SEL_LEVEL_BIT]);
   assign s_start = cfg_slave & ss_act & ~s_act_q & (level_trig | ~ss_prev_act);
   assign s_end = s_act_q & ~ss_act;
   assign s_full = s_act_q & ss_act & level_trig & (samp_cnt_q == len);
   assign s_load = s_start | s_full;
   assign s_push = (s_end & (samp_cnt_q != 6'h00)) | s_full;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_in_q <= 1'b0;
         sclk_prev_q <= 1'b0;
         ss_in_q <= 1'b1;
         ss_prev_q <= 1'b1;
         mosi_in_q <= 1'b0;
         s_act_q <= 1'b0;
      end else begin
         sclk_in_q <= serial_clock_pin_in;
         sclk_prev_q <= sclk_in_q;
         ss_in_q <= select_pin_in;
         ss_prev_q <= ss_in_q;
         mosi_in_q <= master_out_pin_in;
         if (s_start) begin
            s_act_q <= 1'b1;
         end else if (s_end || !cfg_slave) begin
            s_act_q <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // shared shift engine
   // ----------------------------------------
   assign edge_ev = cfg_slave ? (s_act_q & (sclk_in_q ^ sclk_prev_q))
                    : (st_q == ST_SHIFT && tick);
   assign edge_rise = cfg_slave ? sclk_in_q : ~sclk_q;
   assign drive_ev = edge_ev & (edge_rise ^ cfg_q[CTL_DRV_BIT]);
   assign sample_ev = edge_ev & (edge_rise ^ cfg_q[CTL_SMP_BIT]) & (samp_cnt_q < len);
   assign sdi = cfg_slave ? mosi_in_q : master_in_pin_in;
   assign take_any = take_m | s_load;

   // the closing edge may sample while the next word loads; both land
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_q <= '0;
         rx_sh_q <= '0;
         samp_cnt_q <= '0;
         dout_q <= 1'b0;
      end else begin
         if (s_start) begin
            rx_sh_q <= '0;
         end else if (sample_ev) begin
            rx_sh_q[bit_pos(samp_cnt_q, len, cfg_lsb)] <= sdi;
         end
         if (sample_ev) begin
            samp_cnt_q <= samp_cnt_q + 6'h01;
         end
         if (drive_ev && samp_cnt_q < len) begin
            dout_q <= tx_sh_q[bit_pos(samp_cnt_q, len, cfg_lsb)];
         end
         if (take_any) begin
            tx_sh_q <= tx_word;
            dout_q <= tx_word[bit_pos(6'h00, len, cfg_lsb)];
            samp_cnt_q <= '0;
         end
      end
   end
   // ----------------------------------------
   // status and pin drivers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_push_q <= 1'b0;
         done_q <= 1'b0;
         flag_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         // slave words beyond a full receive fifo are dropped
         rx_push_q <= m_done | s_push;
         done_q <= m_done | (s_end & (~level_trig | s_push)) | s_full;
         if (cfg_slave && level_trig && ((s_end && s_push) || s_full)) begin
            flag_q <= (samp_cnt_q == len);
         end
         busy_q <= (st_d != ST_IDLE) | s_act_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_out_q <= 1'b1;
         sclk_oe_n_q <= 1'b1;
         sel_oe_n_q <= 1'b1;
         mo_oe_n_q <= 1'b1;
         mi_oe_n_q <= 1'b1;
      end else begin
         sel_out_q <= (st_d != ST_IDLE) ? sel_q[SEL_LEVEL_BIT] : ~sel_q[SEL_LEVEL_BIT];
         sclk_oe_n_q <= cfg_slave;
         sel_oe_n_q <= cfg_slave;
         mo_oe_n_q <= cfg_slave;
         mi_oe_n_q <= ~(cfg_slave & s_act_q);
      end
   end

   assign serial_clock_pin_out = sclk_q;
   assign serial_clock_pin_oe_n = sclk_oe_n_q;
   assign select_pin_out = sel_out_q;
   assign select_pin_oe_n = sel_oe_n_q;
   assign master_out_pin_out = dout_q;
   assign master_out_pin_oe_n = mo_oe_n_q;
   assign master_in_pin_out = dout_q;
   assign master_in_pin_oe_n = mi_oe_n_q;
   assign busy = busy_q;
   assign transfer_done = done_q;
   assign level_mode_complete_flag = flag_q;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_idle_clock_level: assert property ($rose(busy_q) && !cfg_slave |-> sclk_q == cfg_pol)
      else $error("serial clock not at idle level when a word starts");
   chk_word_edge_count: assert property (m_done |-> edge_cnt_q == {len, 1'b0} - 7'h01)
      else $error("master word ended with wrong edge count");
   chk_clock_on_tick: assert property (st_q == ST_SHIFT && !tick |=> $stable(sclk_q))
      else $error("serial clock moved between divider ticks");
   chk_gap_holds: assert property (m_done && st_d == ST_GAP |=> !take_m)
      else $error("next word started inside the word gap");
   chk_slave_pins: assert property (cfg_slave && $stable(cfg_slave) |=> sclk_oe_n_q && sel_oe_n_q)
      else $error("slave mode drives clock or select");
   chk_select_level: assert property (busy_q && !cfg_slave |-> sel_out_q == sel_q[SEL_LEVEL_BIT])
      else $error("master select not at active level while busy");
   chk_edge_end_flag: assert property (s_end && !level_trig |=> done_q ##1 !done_q)
      else $error("edge mode end did not give one done pulse");
   chk_level_flag_done: assert property ($rose(flag_q) |-> done_q)
      else $error("level flag rose without a done pulse");
   chk_rx_stall: assert property (st_q == ST_IDLE && !rx_in_ready |=> st_q == ST_IDLE)
      else $error("master started with a full receive fifo");
   cov_master_word: cover property (m_done ##1 rx_push_q);
   cov_master_gap: cover property (st_q == ST_GAP ##[1:200] st_q == ST_SHIFT);
   cov_slave_level_full: cover property (s_full);
   cov_slave_early_end: cover property (s_end && level_trig && samp_cnt_q != len);
endmodule

// ===== testbench/spi_peer_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// off-chip slave: answers each word with the previous word it heard
// ----------------------------------------
module spi_peer_model (
   input wire logic sclk,
   input wire logic sel,
   input wire logic sel_lvl,
   input wire logic mosi,
   input wire logic lsb,
   input wire logic smp_neg,
   input wire logic [5:0] len,
   output logic miso
);
   logic [31:0] reply = 32'hA5C3_0F96;
   logic [31:0] got = 32'hA5C3_0F96;
   int k = 0;
   function automatic int pos(input int i);
      return lsb ? i : int'(len) - 1 - i;
   endfunction
   initial miso = 1'b0;
   // ----------------------------------------
   // framing and shifting
   // ----------------------------------------
   always @(sel or sel_lvl) begin
      k = 0;
      if (sel === sel_lvl) miso = reply[pos(0)];
      else miso = ~miso; // a released line must not keep showing the last bit
   end
   // the first edge may be a sample edge, so the first bit is preset at select
   always @(sclk) begin
      if (sel === sel_lvl) begin
         if (sclk === ~smp_neg) begin
            got[pos(k)] = mosi;
            k = k + 1;
            if (k == int'(len)) begin
               reply = got;
               k = 0;
            end
         end else begin
            miso = reply[pos(k)];
         end
      end
   end
endmodule

// ===== testbench/spi_core_transfer_config_tb.sv
`timescale 1ns/1ps
module spi_core_transfer_config_tb;
   import spi_xfer_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic enable = 1'b0;
   logic [31:0] control_word = CTL_RESET;
   logic [SEL_W-1:0] select_config = SEL_RESET;
   logic [DIV_W-1:0] divider = 8'h00;
   logic [WORD_W-1:0] tx_data = 32'h0000_0000;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b1;
   logic tx_ready, rx_valid, busy, transfer_done, level_mode_complete_flag;
   logic [WORD_W-1:0] rx_data;
   logic sck_o, sck_oe_n, sel_o, sel_oe_n, mo_o, mo_oe_n, mi_o, mi_oe_n, peer_mi;
   logic tb_sck = 1'b0, tb_sel = 1'b0, tb_mo = 1'b0;
   logic sck_w, sel_w, mo_w, mi_w;
   logic sel_lvl = 1'b0, lsb = 1'b0, smp_neg = 1'b0, pol = 1'b0, sck_p = 1'b0;
   logic [31:0] echo = 32'hA5C3_0F96;
   logic [31:0] m_e, m_m;
   logic [31:0] exp_q[$], msk_q[$];
   int mismatches = 0, checks = 0, dones = 0, cnt = 0, half = 1, gap = 1, len = 8, ec = 0, sp = 0;
   bit stall = 0, mchk = 0;
   assign sck_w = sck_oe_n ? tb_sck : sck_o;
   assign sel_w = sel_oe_n ? tb_sel : sel_o;
   assign mo_w = mo_oe_n ? tb_mo : mo_o;
   assign mi_w = mi_oe_n ? peer_mi : mi_o;
   always #25 clk = ~clk;
   always @(negedge clk) rx_ready <= stall ? ($urandom() % 3 != 0) : 1'b1;
   spi_core_transfer_config dut (.clk(clk), .rst_n(rst_n), .enable(enable),
      .control_word(control_word), .select_config(select_config), .divider(divider),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .busy(busy), .transfer_done(transfer_done),
      .level_mode_complete_flag(level_mode_complete_flag),
      .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
      .serial_clock_pin_oe_n(sck_oe_n), .select_pin_in(sel_w), .select_pin_out(sel_o),
      .select_pin_oe_n(sel_oe_n), .master_out_pin_in(mo_w), .master_out_pin_out(mo_o),
      .master_out_pin_oe_n(mo_oe_n), .master_in_pin_in(mi_w), .master_in_pin_out(mi_o),
      .master_in_pin_oe_n(mi_oe_n));
   spi_peer_model peer (.sclk(sck_w), .sel(sel_w), .sel_lvl(sel_lvl), .mosi(mo_w),
      .lsb(lsb), .smp_neg(smp_neg), .len(len[5:0]), .miso(peer_mi));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] msk(input int n);
      return n >= 32 ? 32'hFFFF_FFFF : (32'h0000_0001 << n) - 32'h0000_0001;
   endfunction
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // called at a falling edge, returns at one; lim 0 tries a single beat
   task automatic put(input logic [31:0] w, input int lim, output bit ok);
      int i;
      tx_data = w;
      tx_valid = 1'b1;
      for (i = 0; tx_ready !== 1'b1 && i < lim; i++) @(negedge clk);
      ok = (tx_ready === 1'b1);
      @(negedge clk);
   endtask
   task automatic drain();
      int i;
      for (i = 0; i < 20000 && (exp_q.size() > 0 || busy !== 1'b0); i++) @(negedge clk);
      if (i == 20000) begin
         mismatches++;
         summarize();
      end
   endtask
   // ----------------------------------------
   // result watcher
   // ----------------------------------------
   always @(posedge clk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         m_e = exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_0000;
         m_m = msk_q.size() > 0 ? msk_q.pop_front() : 32'hFFFF_FFFF;
         chk("rx word", m_e & m_m, rx_data & m_m);
      end
      if (transfer_done === 1'b1) dones++;
      if (mchk) begin
         chk("master pins", 32'h1, {28'h0, sck_oe_n, sel_oe_n, mo_oe_n, mi_oe_n});
         if (busy !== 1'b1) chk("idle clock", {31'h0, pol}, {31'h0, sck_o});
         else chk("select level", {31'h0, sel_lvl}, {31'h0, sel_o});
      end
      if (mchk && busy === 1'b1) begin
         cnt++;
         if (sck_o !== sck_p) begin
            // after every 2*len edges the next edge opens a word behind the gap
            sp = (ec % (2 * len) == 0) ? gap : half;
            if (cnt > 0) chk("clock spacing", 32'(sp), 32'(cnt));
            ec++;
            cnt = 0;
         end
      end else begin
         cnt = -1000;
         ec = 0;
      end
      sck_p = sck_o;
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic master_run(input logic [31:0] ctl, input logic [7:0] dv, input int nw,
                             input bit fill);
      int i, acc;
      bit ok;
      logic [31:0] w;
      control_word = ctl;
      divider = dv;
      len = ctl[7:3] == 5'h00 ? 32 : int'(ctl[7:3]);
      lsb = ctl[10];
      pol = ctl[11];
      smp_neg = ctl[1];
      sel_lvl = select_config[2];
      half = int'(dv) + 1;
      gap = !ctl[21] ? half : ((ctl[23] ? 13 : 1) + 2 * int'(ctl[15:12])) * half;
      acc = 0;
      dones = 0;
      repeat (3) @(negedge clk);
      mchk = 1;
      enable = !fill;
      for (i = 0; i < nw; i++) begin
         w = $urandom();
         put(w, fill ? 0 : 3000, ok);
         if (!fill) chk("tx accept", 32'h1, {31'h0, ok});
         if (ok) begin
            exp_q.push_back(echo & msk(len));
            msk_q.push_back(msk(len));
            // the peer rewrites only the low len bits of its reply
            echo = (echo & ~msk(len)) | (w & msk(len));
            acc++;
         end
      end
      tx_valid = 1'b0;
      if (fill) chk("fifo depth", 32'(FIFO_DEPTH), 32'(acc));
      enable = 1'b1;
      stall = fill;
      drain();
      chk("word count", 32'(acc), 32'(dones));
      mchk = 0;
      stall = 0;
      enable = 1'b0;
   endtask
   task automatic slave_run(input logic [7:0] sc, input int nb, input logic fl);
      int i;
      bit ok;
      logic [31:0] mo, ti, got;
      // park select at the new idle level first, so no stray frame opens
      tb_sel = ~sc[2];
      control_word = 32'h0004_0444;
      select_config = sc;
      sel_lvl = sc[2];
      lsb = 1'b1;
      len = 8;
      mo = $urandom();
      ti = $urandom();
      got = 32'h0000_0000;
      repeat (3) @(negedge clk);
      tb_sel = ~sc[2];
      put(ti, 3000, ok);
      chk("tx accept", 32'h1, {31'h0, ok});
      tx_valid = 1'b0;
      exp_q.push_back(mo);
      msk_q.push_back(msk(nb));
      repeat (6) @(negedge clk);
      chk("slave pins", 32'h7, {29'h0, sck_oe_n, sel_oe_n, mo_oe_n});
      dones = 0;
      tb_sel = sc[2];
      repeat (4) @(negedge clk);
      for (i = 0; i < nb; i++) begin
         tb_mo = mo[i];
         repeat (4) @(negedge clk);
         got[i] = mi_w;
         tb_sck = 1'b1;
         repeat (4) @(negedge clk);
         tb_sck = 1'b0;
      end
      repeat (4) @(negedge clk);
      tb_sel = ~sc[2];
      repeat (12) @(negedge clk);
      drain();
      chk("slave reply", ti & msk(nb), got & msk(nb));
      chk("slave done", 32'h1, 32'(dones));
      if (!sc[4]) chk("full flag", {31'h0, fl}, {31'h0, level_mode_complete_flag});
   endtask
   initial begin
      int seed;
      seed = $urandom(32'h94607c64);
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      master_run(32'h0000_F044, 8'h00, 3, 1'b0);
      master_run(32'h0020_5C82, 8'h01, 3, 1'b0);
      master_run(32'h00A0_3004, 8'h00, 10, 1'b1);
      slave_run(8'h04, 8, 1'b1);
      slave_run(8'h00, 5, 1'b0);
      slave_run(8'h10, 8, 1'b1);
      summarize();
   end
endmodule
